// *** verilog/lmcc_pkg.sv ***
// constants, types and command codes for the led matrix command interpreter
// assumes a byte-wide command stream already deframed by the serial front end
// Function
// - command 33h data: bit7 picks blink (1) or fade (0) output style
// - new blink setting takes effect at next frame timing-1 phase
// - blink period code 0..7 maps to off,256,512,1024,1536,2048,2560,3072 frames
// - one frame is (256+16)*9 system oscillator periods
// - blink period counted in whole oscillator periods
// - undefined data values leave setting and function unchanged
// - command 34h: role 01 drives oscillator out, 10 takes it in
// - roles 00 and 11 leave cascade clock pin undriven
// - command 35h: run enable bit1, display enable bit0, standby disables thermal guard
// - command 36h: 4-bit drive current code, (n+1)*3 mA, reset 1010
// - command 37h: 8-bit dimming code gives duty code/255, reset ffh
// - one dimming duty for every dot, luminance is current times duty
// - command 38h: guard bit7, auto-blank bit6, open test bit1, short test bit0
// - guard and auto-blank blank display when over 150 degrees reported
// - auto-blank restores display once below 125 degrees reported
// - guard without auto-blank sets overheat flag above 150 degrees
// - user thermal mode clears overheat flag below 125 degrees
// - setting open or short test enable starts a detection run
// - during detection other modes are ignored, matrix rescans for detection
// - command 70h returns stored settings in fixed eight-byte order
package lmcc_pkg;
    localparam logic [7:0] CMD_BLINK     = 8'h33;
    localparam logic [7:0] CMD_ROLE      = 8'h34;
    localparam logic [7:0] CMD_RUN       = 8'h35;
    localparam logic [7:0] CMD_CURRENT   = 8'h36;
    localparam logic [7:0] CMD_DIMMING   = 8'h37;
    localparam logic [7:0] CMD_PROTECT   = 8'h38;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] RST_BLINK     = 8'h00;
    localparam logic [1:0] RST_ROLE      = 2'h0;
    localparam logic [1:0] RST_RUN       = 2'h0;
    localparam logic [3:0] RST_CURRENT   = 4'ha;
    localparam logic [7:0] RST_DIMMING   = 8'hff;
    localparam logic [3:0] RST_PROTECT   = 4'h0;
    localparam logic [7:0] RST_PICTURE   = 8'h00; // picture/movie byte, not held here
    localparam logic [7:0] RST_GRAY      = 8'h00; // binary/gray byte, not held here
    localparam logic [7:0] RST_FADE      = 8'h4a; // fade parameter byte, not held here
    localparam int         BLINK_STYLE_BIT = 7;
    localparam int         FRAME_LINES   = 256 + 16;
    localparam int         FRAME_SLOTS   = 9;
    localparam int         FRAME_OSC     = FRAME_LINES * FRAME_SLOTS;
    localparam logic [11:0] FRAME_OSC_LAST = 12'(FRAME_OSC - 1);
    localparam logic [11:0] TIMING1_LEN  = 12'(FRAME_LINES - 1); // first line slot
    localparam int         FRAMES_UNIT   = 256;
    localparam logic [1:0] ROLE_MASTER   = 2'h1;
    localparam logic [1:0] ROLE_SLAVE    = 2'h2;
    localparam int         STATUS_BYTES  = 8;

    // stored settings, grouped as in the status readback except the unread protection bits
    typedef struct packed {
        logic       blink_style_select;
        logic [2:0] blink_period_code;
        logic       chain_role_hi;
        logic       chain_role_lo;
        logic       clock_run_enable;
        logic       display_enable;
        logic [3:0] drive_current_code;
        logic [7:0] dimming_duty_code;
        logic       thermal_guard_enable;
        logic       thermal_auto_blank;
        logic       open_test_enable;
        logic       short_test_enable;
    } lmcc_cfg_type;

    // one received byte from the serial front end
    typedef struct packed {
        logic       valid;
        logic       first;  // first byte after a start condition
        logic [7:0] data;
    } lmcc_byte_type;
endpackage

// *** verilog/lmcc_sync.sv ***
// two-flop synchroniser for one level from outside the clock domain
// assumes nothing beyond ref_clk and rst
`timescale 1ns/1ps
module lmcc_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta;

    // first stage is read by the second stage only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // lmcc_sync

// *** verilog/lmcc_frame.sv ***
// frame timer on the system oscillator; gives frame start, timing-1 and blink phase
// assumes osc_tick is a one-cycle pulse per oscillator period, on ref_clk
`timescale 1ns/1ps
module lmcc_frame
    import lmcc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       osc_tick,
    input  wire logic [2:0] period_code,
    output logic            timing1_start,
    output logic            blink_phase
);
    logic [11:0] osc_count;
    logic [11:0] frame_count;
    logic [11:0] half_frames;

    // frames per half blink period: code 1,2 -> 128, 256; 3..7 -> 2,3,4,5,6 x 256
    always_comb begin
        unique case (period_code)
            3'd1:    half_frames = 12'(FRAMES_UNIT / 2);
            3'd2:    half_frames = 12'(FRAMES_UNIT);
            3'd3:    half_frames = 12'(FRAMES_UNIT * 2);
            3'd4:    half_frames = 12'(FRAMES_UNIT * 3);
            3'd5:    half_frames = 12'(FRAMES_UNIT * 4);
            3'd6:    half_frames = 12'(FRAMES_UNIT * 5);
            3'd7:    half_frames = 12'(FRAMES_UNIT * 6);
            default: half_frames = 12'h000;
        endcase
    end

    assign timing1_start = osc_tick && (osc_count == 12'h000);

    // frame of whole oscillator periods
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_count <= 12'h000;
        end else if (osc_tick) begin
            osc_count <= (osc_count == FRAME_OSC_LAST) ? 12'h000 : osc_count + 12'h001;
        end
    end

    // blink phase toggles each half period, counted in frames
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_count <= 12'h000;
            blink_phase <= 1'b1;
        end else if (half_frames == 12'h000) begin
            frame_count <= 12'h000;
            blink_phase <= 1'b1;
        end else if (timing1_start) begin
            if (frame_count >= half_frames - 12'h001) begin
                frame_count <= 12'h000;
                blink_phase <= ~blink_phase;
            end else begin
                frame_count <= frame_count + 12'h001;
            end
        end
    end
endmodule // lmcc_frame

// *** verilog/lmcc_top.sv ***
// command interpreter and configuration store for the led matrix driver
// assumes a deframed byte stream in, status bytes pulled out one per read strobe
`timescale 1ns/1ps
module lmcc_top
    import lmcc_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire lmcc_byte_type rx_byte,
    input  wire logic          rd_strobe,
    output logic [7:0]         rd_data,
    output logic               rd_valid,
    input  wire logic          osc_int,
    input  wire logic          sync_clk_in,
    output logic               sync_clk_out,
    output logic               sync_clk_oe,
    input  wire logic          temp_hot,
    input  wire logic          temp_cool,
    output logic               overheat_flag,
    output lmcc_cfg_type       cfg,
    output logic               blink_style_active,
    output logic [2:0]         blink_period_active,
    output logic               osc_running,
    output logic               display_on,
    output logic               column_current_outputs,
    output logic [3:0]         drive_current_level,
    output logic               open_test_start,
    output logic               short_test_start,
    output logic               detect_active
);
    logic       have_cmd;
    logic [7:0] cmd;
    logic       status_mode;
    logic [2:0] status_idx;
    logic       osc_int_s;
    logic       sync_in_s;
    logic       hot_s;
    logic       cool_s;
    logic       osc_src;
    logic       osc_src_d;
    logic       osc_tick;
    logic       timing1_start;
    logic       blink_phase;
    logic       blink_pending;
    logic [7:0] blink_staged;
    logic       thermal_blank;
    logic [7:0] pwm_count;
    logic       pwm_on;
    logic       data_take;
    logic [7:0] d;

    // pin inputs pass two flops
    lmcc_sync u_sync_osc  (.ref_clk(ref_clk), .rst(rst), .async_in(osc_int),     .sync_out(osc_int_s));
    lmcc_sync u_sync_clk  (.ref_clk(ref_clk), .rst(rst), .async_in(sync_clk_in), .sync_out(sync_in_s));
    lmcc_sync u_sync_hot  (.ref_clk(ref_clk), .rst(rst), .async_in(temp_hot),    .sync_out(hot_s));
    lmcc_sync u_sync_cool (.ref_clk(ref_clk), .rst(rst), .async_in(temp_cool),   .sync_out(cool_s));

    // command byte then data byte
    assign data_take = rx_byte.valid && !rx_byte.first && have_cmd;
    assign d         = rx_byte.data;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            have_cmd <= 1'b0;
            cmd      <= 8'h00;
        end else if (rx_byte.valid) begin
            if (rx_byte.first || !have_cmd) begin
                have_cmd <= 1'b1;
                cmd      <= d;
            end else begin
                have_cmd <= 1'b0;
            end
        end
    end

    // role, run, current, dimming, protection registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {cfg.chain_role_hi, cfg.chain_role_lo}       <= RST_ROLE;
            {cfg.clock_run_enable, cfg.display_enable}   <= RST_RUN;
            cfg.drive_current_code                       <= RST_CURRENT;
            cfg.dimming_duty_code                        <= RST_DIMMING;
            {cfg.thermal_guard_enable, cfg.thermal_auto_blank,
             cfg.open_test_enable, cfg.short_test_enable} <= RST_PROTECT;
        end else if (data_take) begin
            unique case (cmd)
                CMD_ROLE:    {cfg.chain_role_hi, cfg.chain_role_lo} <= d[1:0];
                CMD_RUN:     {cfg.clock_run_enable, cfg.display_enable} <= d[1:0];
                CMD_CURRENT: cfg.drive_current_code <= d[3:0];
                CMD_DIMMING: cfg.dimming_duty_code <= d;
                CMD_PROTECT: {cfg.thermal_guard_enable, cfg.thermal_auto_blank,
                              cfg.open_test_enable, cfg.short_test_enable} <= {d[7:6], d[1:0]};
                default:     ;
            endcase
        end
    end

    // blink setting is stored now and applied at the next timing-1
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg.blink_style_select <= RST_BLINK[BLINK_STYLE_BIT];
            cfg.blink_period_code  <= RST_BLINK[2:0];
            blink_staged           <= RST_BLINK;
            blink_pending          <= 1'b0;
            blink_style_active     <= RST_BLINK[BLINK_STYLE_BIT];
            blink_period_active    <= RST_BLINK[2:0];
        end else begin
            if (data_take && cmd == CMD_BLINK) begin
                cfg.blink_style_select <= d[BLINK_STYLE_BIT];
                cfg.blink_period_code  <= d[2:0];
                blink_staged           <= d;
                blink_pending          <= 1'b1;
            end else if (timing1_start && blink_pending) begin
                blink_pending <= 1'b0;
            end
            if (timing1_start && blink_pending && !(data_take && cmd == CMD_BLINK)) begin
                blink_style_active  <= blink_staged[BLINK_STYLE_BIT];
                blink_period_active <= blink_staged[2:0];
            end
        end
    end

    // oscillator source by role; slave uses cascade pin, others the internal one
    assign osc_src = ({cfg.chain_role_hi, cfg.chain_role_lo} == ROLE_SLAVE) ? sync_in_s : osc_int_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_src_d <= 1'b0;
        end else begin
            osc_src_d <= osc_src;
        end
    end

    // one tick per rising oscillator edge, only while running
    assign osc_tick = osc_src && !osc_src_d && cfg.clock_run_enable;

    lmcc_frame u_frame (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .osc_tick      (osc_tick),
        .period_code   (blink_period_active),
        .timing1_start (timing1_start),
        .blink_phase   (blink_phase)
    );

    // cascade pin: master drives oscillator out, else undriven
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_clk_out <= 1'b0;
            sync_clk_oe  <= 1'b0;
        end else begin
            sync_clk_oe  <= ({cfg.chain_role_hi, cfg.chain_role_lo} == ROLE_MASTER);
            sync_clk_out <= ({cfg.chain_role_hi, cfg.chain_role_lo} == ROLE_MASTER) &&
                            cfg.clock_run_enable && osc_int_s;
        end
    end

    // thermal hysteresis: hot sets, cool clears, hot wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            thermal_blank <= 1'b0;
            overheat_flag <= 1'b0;
        end else if (!cfg.thermal_guard_enable || !cfg.clock_run_enable) begin
            thermal_blank <= 1'b0;
            overheat_flag <= 1'b0;
        end else if (cfg.thermal_auto_blank) begin
            overheat_flag <= 1'b0;
            if (hot_s) begin
                thermal_blank <= 1'b1;
            end else if (cool_s) begin
                thermal_blank <= 1'b0;
            end
        end else begin
            thermal_blank <= 1'b0;
            if (hot_s) begin
                overheat_flag <= 1'b1;
            end else if (cool_s) begin
                overheat_flag <= 1'b0;
            end
        end
    end

    // global pwm count, one duty for all dots
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_count <= 8'h00;
        end else if (osc_tick) begin
            pwm_count <= (pwm_count == 8'hfe) ? 8'h00 : pwm_count + 8'h01;
        end
    end

    assign pwm_on = (pwm_count < cfg.dimming_duty_code);

    // output drive and detection control
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_running            <= 1'b0;
            display_on             <= 1'b0;
            column_current_outputs <= 1'b0;
            drive_current_level    <= RST_CURRENT;
            open_test_start        <= 1'b0;
            short_test_start       <= 1'b0;
            detect_active          <= 1'b0;
        end else begin
            osc_running         <= cfg.clock_run_enable;
            drive_current_level <= cfg.drive_current_code;
            detect_active       <= cfg.open_test_enable || cfg.short_test_enable;
            open_test_start     <= data_take && cmd == CMD_PROTECT && d[1] && !cfg.open_test_enable;
            short_test_start    <= data_take && cmd == CMD_PROTECT && d[0] && !cfg.short_test_enable;
            if (cfg.open_test_enable || cfg.short_test_enable) begin
                display_on             <= 1'b0;
                column_current_outputs <= cfg.clock_run_enable;
            end else begin
                display_on <= cfg.clock_run_enable && cfg.display_enable && !thermal_blank &&
                              (!blink_style_active || blink_phase);
                column_current_outputs <= cfg.clock_run_enable && cfg.display_enable &&
                              !thermal_blank && pwm_on &&
                              (!blink_style_active || blink_phase);
            end
        end
    end

    // status readback after command 70h, eight bytes in order
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_mode <= 1'b0;
            status_idx  <= 3'h0;
            rd_data     <= 8'h00;
            rd_valid    <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (rx_byte.valid) begin
                status_mode <= (rx_byte.first || !have_cmd) && d == CMD_STATUS;
                status_idx  <= 3'h0;
            end else if (rd_strobe && status_mode) begin
                rd_valid   <= 1'b1;
                status_idx <= status_idx + 3'h1;
                unique case (status_idx)
                    3'd0: rd_data <= RST_PICTURE;
                    3'd1: rd_data <= RST_GRAY;
                    3'd2: rd_data <= RST_FADE;
                    3'd3: rd_data <= {cfg.blink_style_select, 4'h0, cfg.blink_period_code};
                    3'd4: rd_data <= {6'h00, cfg.chain_role_hi, cfg.chain_role_lo};
                    3'd5: rd_data <= {6'h00, cfg.clock_run_enable, cfg.display_enable};
                    3'd6: rd_data <= {4'h0, cfg.drive_current_code};
                    3'd7: rd_data <= cfg.dimming_duty_code;
                endcase
            end
        end
    end
endmodule // lmcc_top

// *** bench/lmcc_top_sva.sv ***
// port-level assertions for the led matrix command interpreter
// assumes one ref_clk domain with rst asynchronous, active high
`timescale 1ns/1ps
module lmcc_top_sva
    import lmcc_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          rst,
    input wire lmcc_byte_type rx_byte,
    input wire logic          rd_valid,
    input wire logic          sync_clk_out,
    input wire logic          sync_clk_oe,
    input wire logic          temp_hot,
    input wire logic          overheat_flag,
    input wire lmcc_cfg_type  cfg,
    input wire logic [2:0]    blink_period_active,
    input wire logic          osc_running,
    input wire logic          display_on,
    input wire logic          column_current_outputs,
    input wire logic [3:0]    drive_current_level,
    input wire logic          open_test_start,
    input wire logic          detect_active
);
    logic       pend;
    logic [7:0] pend_cmd;
    logic       data_wr;
    logic       hot_run;
    // remember which command the next data byte belongs to
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend     <= 1'b0;
            pend_cmd <= 8'h00;
        end else if (rx_byte.valid) begin
            pend     <= rx_byte.first || !pend;
            pend_cmd <= (rx_byte.first || !pend) ? rx_byte.data : pend_cmd;
        end
    end
    // data byte taken, and thermal guard live while hot
    assign data_wr = rx_byte.valid && !rx_byte.first && pend;
    assign hot_run = cfg.thermal_guard_enable && cfg.clock_run_enable && temp_hot;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_current_write: assert property (data_wr && pend_cmd == CMD_CURRENT |=>
        cfg.drive_current_code == $past(rx_byte.data[3:0])) else $error("current code not stored");
    chk_dimming_write: assert property (data_wr && pend_cmd == CMD_DIMMING |=>
        cfg.dimming_duty_code == $past(rx_byte.data)) else $error("dimming code not stored");
    chk_cmd_only: assert property (rx_byte.valid && !data_wr |=> $stable(cfg))
        else $error("settings changed on a command byte");
    chk_level_follow: assert property (drive_current_level == $past(cfg.drive_current_code))
        else $error("drive level does not follow code");
    chk_master_drive: assert property ({cfg.chain_role_hi, cfg.chain_role_lo} == ROLE_MASTER [*2]
        |-> sync_clk_oe) else $error("master role not driving pin");
    chk_idle_float: assert property ({cfg.chain_role_hi, cfg.chain_role_lo} != ROLE_MASTER [*2]
        |-> !sync_clk_oe && !sync_clk_out) else $error("pin driven outside master role");
    chk_standby_dark: assert property (!cfg.clock_run_enable [*2]
        |-> !display_on && !osc_running && !overheat_flag) else $error("standby not dark");
    chk_auto_blank: assert property (hot_run && cfg.thermal_auto_blank [*6] |-> !display_on && !column_current_outputs)
        else $error("display not blanked when hot");
    chk_flag_set: assert property (hot_run && !cfg.thermal_auto_blank [*6] |-> overheat_flag)
        else $error("overheat flag not set");
    chk_detect_dark: assert property (detect_active [*2] |-> !display_on)
        else $error("display on during detection");
    chk_open_start: assert property ($rose(cfg.open_test_enable) |-> ##[0:1] open_test_start)
        else $error("open test did not start");
    cover property (rd_valid);
    cover property ($rose(overheat_flag));
    cover property ($changed(blink_period_active));
endmodule // lmcc_top_sva
bind lmcc_top lmcc_top_sva i_lmcc_top_sva (.ref_clk(ref_clk), .rst(rst), .rx_byte(rx_byte),
    .rd_valid(rd_valid), .sync_clk_out(sync_clk_out), .sync_clk_oe(sync_clk_oe), .temp_hot(temp_hot),
    .overheat_flag(overheat_flag), .cfg(cfg), .blink_period_active(blink_period_active),
    .osc_running(osc_running), .display_on(display_on), .column_current_outputs(column_current_outputs),
    .drive_current_level(drive_current_level), .open_test_start(open_test_start),
    .detect_active(detect_active));

// *** bench/lmcc_host.sv ***
// host model: sends command and data bytes, pulls status bytes
// assumes inputs change 1 ns after the ref_clk rising edge
`timescale 1ns/1ps
module lmcc_host
    import lmcc_pkg::*;
(
    input  wire logic       ref_clk,
    output lmcc_byte_type   rx_byte,
    output logic            rd_strobe,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    // idle bus at time zero
    initial begin
        rx_byte = 10'h000;
        rd_strobe = 1'b0;
    end
    // one byte for one cycle
    task automatic put(input logic first, input logic [7:0] d);
        @(posedge ref_clk);
        #1 rx_byte = {1'b1, first, d};
    endtask
    // released data shows the inverse of the last byte
    task automatic release_bus();
        @(posedge ref_clk);
        #1 rx_byte = {1'b0, 1'b0, ~rx_byte.data};
    endtask
    // command byte then its data byte, back to back
    task automatic send(input logic [7:0] cmd, input logic [7:0] dat);
        put(1'b1, cmd);
        put(1'b0, dat);
        release_bus();
    endtask
    // one read strobe, answer taken the cycle after
    task automatic fetch(output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        #1 rd_strobe = 1'b1;
        @(posedge ref_clk);
        #1 rd_strobe = 1'b0;
        d = rd_data;
        v = rd_valid;
    endtask
endmodule // lmcc_host

// *** bench/testbench.sv ***
// self-checking bench for the led matrix command interpreter
// assumes lmcc_top, lmcc_host and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
    import lmcc_pkg::*;
    logic          ref_clk, rst, osc_int, sync_clk_in, temp_hot, temp_cool, rd_strobe, rd_valid, v;
    logic          sync_clk_out, sync_clk_oe, overheat_flag, blink_style_active, osc_running;
    logic          display_on, column_current_outputs, open_test_start, short_test_start, detect_active;
    logic [7:0]    rd_data, d;
    logic [7:0]    exp_st [8];
    logic [2:0]    blink_period_active;
    logic [3:0]    drive_current_level;
    lmcc_byte_type rx_byte;
    lmcc_cfg_type  cfg;
    int            num_errors, samples_checked, starts = 0;
    lmcc_top i_lmcc_top (.ref_clk(ref_clk), .rst(rst), .rx_byte(rx_byte), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .rd_valid(rd_valid), .osc_int(osc_int), .sync_clk_in(sync_clk_in),
        .sync_clk_out(sync_clk_out), .sync_clk_oe(sync_clk_oe), .temp_hot(temp_hot), .temp_cool(temp_cool),
        .overheat_flag(overheat_flag), .cfg(cfg), .blink_style_active(blink_style_active),
        .blink_period_active(blink_period_active), .osc_running(osc_running), .display_on(display_on),
        .column_current_outputs(column_current_outputs), .drive_current_level(drive_current_level),
        .open_test_start(open_test_start), .short_test_start(short_test_start), .detect_active(detect_active));
    lmcc_host i_lmcc_host (.ref_clk(ref_clk), .rx_byte(rx_byte), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .rd_valid(rd_valid));
    // 50 ns system clock and unrelated 400 ns oscillator
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        osc_int = 1'b0;
        #37;
        forever #200 osc_int = ~osc_int;
    end
    // cascade pin input follows a delayed copy of the oscillator
    assign #13 sync_clk_in = osc_int;
    // count detection start pulses
    always @(posedge ref_clk) if (open_test_start || short_test_start) starts <= starts + 1;
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog well beyond two frames plus the command traffic
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        rst = 1'b1;
        temp_hot = 1'b0;
        temp_cool = 1'b1;
        num_errors = 0;
        samples_checked = 0;
        step(16);
        rst = 1'b0;
        chk(cfg, {8'h00, RST_CURRENT, RST_DIMMING, RST_PROTECT}, "reset settings");
        chk(drive_current_level, RST_CURRENT, "reset level");
        chk(sync_clk_oe, 1'b0, "reset pin");
        $display("test reset done");
        // every role code, chosen before the oscillator runs
        for (int k = 0; k < 4; k++) begin
            i_lmcc_host.send(CMD_ROLE, {6'h00, 2'(k + 1)});
            step(2);
            chk({sync_clk_oe, sync_clk_out}, {2'(k + 1) == ROLE_MASTER, 1'b0}, "role pin");
        end
        $display("test role done");
        i_lmcc_host.send(CMD_CURRENT, 8'hf3);
        step(2);
        chk(drive_current_level, 4'h3, "current unused bits");
        i_lmcc_host.put(1'b1, CMD_CURRENT);
        i_lmcc_host.send(CMD_DIMMING, 8'h80);
        step(2);
        chk({cfg.dimming_duty_code, cfg.drive_current_code}, 12'h803, "aborted command");
        $display("test current done");
        for (int k = 1; k < 4; k++) begin
            i_lmcc_host.send(CMD_RUN, 8'(k));
            step(2);
            chk({osc_running, display_on}, k[1] ? 2'(k) : 2'h0, "run control");
        end
        $display("test run done");
        // hot and cool indications drive separately
        i_lmcc_host.send(CMD_PROTECT, 8'hc0);
        temp_hot = 1'b1;
        temp_cool = 1'b0;
        step(8);
        chk({display_on, overheat_flag, column_current_outputs}, 3'h0, "auto blank");
        temp_hot = 1'b0;
        temp_cool = 1'b1;
        step(8);
        chk(display_on, 1'b1, "auto restore");
        i_lmcc_host.send(CMD_PROTECT, 8'h80);
        temp_hot = 1'b1;
        temp_cool = 1'b0;
        step(8);
        chk({display_on, overheat_flag}, 2'h3, "user flag set");
        temp_hot = 1'b0;
        temp_cool = 1'b1;
        step(8);
        chk(overheat_flag, 1'b0, "user flag clear");
        $display("test thermal done");
        i_lmcc_host.send(CMD_BLINK, 8'h81);
        step(1);
        chk({cfg.blink_style_select, cfg.blink_period_code, blink_period_active}, 7'h48, "blink stored");
        exp_st = '{RST_PICTURE, RST_GRAY, RST_FADE, 8'h81, 8'h00, 8'h03, 8'h03, 8'h80};
        i_lmcc_host.put(1'b1, CMD_STATUS);
        i_lmcc_host.release_bus();
        for (int k = 0; k < 9; k++) begin
            i_lmcc_host.fetch(d, v);
            chk({v, d}, {1'b1, exp_st[k % 8]}, "status byte");
        end
        $display("test status done");
        for (int n = 0; n < 40000 && blink_period_active !== 3'h1; n++) @(posedge ref_clk);
        #1;
        chk({blink_style_active, blink_period_active}, 4'h9, "blink applied");
        $display("test blink done");
        i_lmcc_host.send(CMD_CURRENT, 8'h02);
        i_lmcc_host.send(CMD_PROTECT, 8'h02);
        step(3);
        chk({detect_active, display_on}, 2'h2, "open detect");
        i_lmcc_host.send(CMD_PROTECT, 8'h01);
        step(3);
        chk(starts, 2, "detect starts");
        $display("test detect done");
        summarize();
    end
endmodule // testbench
